// File: verilog/ceis_pkg.sv
// Constants for the comparator edge interrupt selector
package ceis_pkg;

  // Bus geometry
  localparam int          ADR_W         = 18;
  localparam int          DAT_W         = 32;
  localparam int          IDX_W         = 16;
  localparam int          REG_W         = 8;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_RISE_LOW  = 16'hFF48;
  localparam logic [15:0] IDX_FALL_LOW  = 16'hFF49;
  localparam logic [15:0] IDX_RISE_HIGH = 16'hFF4A;
  localparam logic [15:0] IDX_FALL_HIGH = 16'hFF4B;
  localparam logic [15:0] IDX_IRQ_STAT  = 16'hFF4C;
  localparam logic [15:0] IDX_IRQ_MASK  = 16'hFF4D;

  // Reset values
  localparam logic [7:0]  EDGE_RST      = 8'h00;
  localparam logic [2:0]  STAT_RST      = 3'h0;
  localparam logic [2:0]  MASK_RST      = 3'h0;

  // Field layout
  localparam int          NUM_SRC       = 3;
  localparam int          SRC_BIT_FIRST = 6;
  localparam int          HIGH_IMPL_BIT = 0;
  localparam int          ENABLE_W      = 9;

endpackage : ceis_pkg

// File: verilog/ceis_edge_detect.sv
// Synchroniser and selectable edge detector for one comparator output
`timescale 1ns/1ns
module ceis_edge_detect
  import ceis_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Comparator level from the analog side
  input  wire logic cmpIn,
  // Edge selection
  input  wire logic riseEn,
  input  wire logic fallEn,
  // Request pulse
  output logic      irqPulse
);

  logic syncMetaReg;
  logic syncReg;
  logic prevReg;
  logic primeAReg;
  logic primeBReg;
  logic primedReg;
  logic irqReg;
  logic riseSeen;
  logic fallSeen;
  logic irqNext;

  // Analog level is asynchronous: two flops before use
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      syncMetaReg <= 1'b0;
      syncReg     <= 1'b0;
    end else begin
      syncMetaReg <= cmpIn;
      syncReg     <= syncMetaReg;
    end
  end

  // Compare only once sync and previous stages hold real samples;
  // a high level at reset release must not look like an edge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prevReg   <= 1'b0;
      primeAReg <= 1'b0;
      primeBReg <= 1'b0;
      primedReg <= 1'b0;
      irqReg    <= 1'b0;
    end else begin
      prevReg   <= syncReg;                                   // [R08]
      primeAReg <= 1'b1;
      primeBReg <= primeAReg;
      primedReg <= primeBReg;
      irqReg    <= irqNext;
    end
  end

  assign riseSeen = primedReg & syncReg & ~prevReg;           // [R08]
  assign fallSeen = primedReg & ~syncReg & prevReg;           // [R08]
  // Neither bit: off; one bit: that edge; both: either edge
  assign irqNext  = (riseEn & riseSeen) | (fallEn & fallSeen); // [R05]
  assign irqPulse = irqReg;

  property p_rise_fires;
    @(posedge mclk) disable iff (sys_rst)
      (riseEn && primedReg && syncReg && !prevReg) |=> irqPulse;
  endproperty
  chk_rise_edge_fires: assert property (p_rise_fires) // [R05]
    else $error("enabled rising edge gave no request");

  property p_fall_fires;
    @(posedge mclk) disable iff (sys_rst)
      (fallEn && primedReg && !syncReg && prevReg) |=> irqPulse;
  endproperty
  chk_fall_edge_fires: assert property (p_fall_fires) // [R05]
    else $error("enabled falling edge gave no request");

  property p_disabled_quiet;
    @(posedge mclk) disable iff (sys_rst)
      (!riseEn && !fallEn) |=> !irqPulse;
  endproperty
  chk_disabled_quiet: assert property (p_disabled_quiet) // [R05]
    else $error("request raised while detection disabled");

  property p_irq_has_cause;
    @(posedge mclk) disable iff (sys_rst)
      irqPulse |-> $past(syncReg) != $past(prevReg);
  endproperty
  chk_irq_has_cause: assert property (p_irq_has_cause) // [R08]
    else $error("request without a level change");

endmodule : ceis_edge_detect

// File: verilog/ceis_edge_select.sv
// Comparator edge interrupt selector with Wishbone register slave
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ns
// Functional notes
// [R01] Edge enables per comparator interrupt zero-two
// [R02] Rise and fall pairs share bit positions
// [R03] Registers byte writable and readable
// [R04] All enable registers reset to zero
// [R05] Enable pair selects none, fall, rise, both
// [R06] Bits six-eight drive comparator requests zero-two
// [R07] Software keeps upper register bits 1-7 zero
// [R08] Sampled level compared; one-cycle request on edge
module ceis_edge_select
  import ceis_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [DAT_W-1:0] wb_dat_i,
  output logic      [DAT_W-1:0] wb_dat_o,
  output logic                  wb_ack_o,
  // Comparator levels
  input  wire logic             comparator0Out,
  input  wire logic             comparator1Out,
  input  wire logic             comparator2Out,
  // Request pulses
  output logic                  comparator0Irq,
  output logic                  comparator1Irq,
  output logic                  comparator2Irq,
  // Summary interrupt
  output logic                  irqOut
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  function automatic logic hitIdx(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] want);
    hitIdx = (idx == want);
  endfunction : hitIdx

  logic [REG_W-1:0]    riseLowReg;
  logic [REG_W-1:0]    fallLowReg;
  logic                riseHighReg;
  logic                fallHighReg;
  logic [NUM_SRC-1:0]  statusReg;
  logic [NUM_SRC-1:0]  maskReg;
  logic                ackReg;
  logic [DAT_W-1:0]    datReg;

  logic                ackNext;
  logic                busWrite;
  logic                busRead;
  logic                laneWrite;
  logic [IDX_W-1:0]    regIdx;
  logic                selRiseLow;
  logic                selFallLow;
  logic                selRiseHigh;
  logic                selFallHigh;
  logic                selStat;
  logic                selMask;
  logic [REG_W-1:0]    readByte;
  logic [DAT_W-1:0]    datNext;
  logic [ENABLE_W-1:0] riseAll;
  logic [ENABLE_W-1:0] fallAll;
  logic [NUM_SRC-1:0]  riseSrc;
  logic [NUM_SRC-1:0]  fallSrc;
  logic [NUM_SRC-1:0]  cmpLevel;
  logic [NUM_SRC-1:0]  irqVec;
  logic [NUM_SRC-1:0]  statusNext;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  // One wait state: ack the cycle after the strobe, drop it after
  assign ackNext     = wb_cyc_i & wb_stb_i & ~ackReg;
  assign busWrite    = ackNext & wb_we_i;
  assign busRead     = ackNext & ~wb_we_i;
  assign laneWrite   = busWrite & wb_sel_i[0];                 // [R03]
  assign regIdx      = wb_adr_i[ADR_W-1:2];
  assign selRiseLow  = hitIdx(regIdx, IDX_RISE_LOW);
  assign selFallLow  = hitIdx(regIdx, IDX_FALL_LOW);
  assign selRiseHigh = hitIdx(regIdx, IDX_RISE_HIGH);
  assign selFallHigh = hitIdx(regIdx, IDX_FALL_HIGH);
  assign selStat     = hitIdx(regIdx, IDX_IRQ_STAT);
  assign selMask     = hitIdx(regIdx, IDX_IRQ_MASK);

  // Unmapped addresses still ack and read zero
  assign readByte =
      selRiseLow  ? riseLowReg :
      selFallLow  ? fallLowReg :
      selRiseHigh ? {{(REG_W-1){1'b0}}, riseHighReg} :
      selFallHigh ? {{(REG_W-1){1'b0}}, fallHighReg} :
      selStat     ? {{(REG_W-NUM_SRC){1'b0}}, statusReg} :
      selMask     ? {{(REG_W-NUM_SRC){1'b0}}, maskReg} :
                    EDGE_RST;                                  // [R03]
  assign datNext  = {{(DAT_W-REG_W){1'b0}}, readByte};

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ackReg <= 1'b0;
      datReg <= '0;
    end else begin
      ackReg <= ackNext;
      if (busRead) begin
        datReg <= datNext;
      end
    end
  end

  assign wb_ack_o = ackReg;
  assign wb_dat_o = datReg;

  ////////////////////////////////////////////////////////////////////////
  // Edge enable registers

  // Upper registers hold only bit 0; bits above are not stored
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      riseLowReg  <= EDGE_RST;                                 // [R04]
      fallLowReg  <= EDGE_RST;                                 // [R04]
      riseHighReg <= EDGE_RST[HIGH_IMPL_BIT];                  // [R04]
      fallHighReg <= EDGE_RST[HIGH_IMPL_BIT];                  // [R04]
      maskReg     <= MASK_RST;
    end else if (laneWrite) begin
      if (selRiseLow) begin
        riseLowReg <= wb_dat_i[REG_W-1:0];                     // [R01]
      end
      if (selFallLow) begin
        fallLowReg <= wb_dat_i[REG_W-1:0];                     // [R01]
      end
      if (selRiseHigh) begin
        riseHighReg <= wb_dat_i[HIGH_IMPL_BIT];                // [R07]
      end
      if (selFallHigh) begin
        fallHighReg <= wb_dat_i[HIGH_IMPL_BIT];                // [R07]
      end
      if (selMask) begin
        maskReg <= wb_dat_i[NUM_SRC-1:0];
      end
    end
  end

  // Same bit position n in both pairs serves one source
  assign riseAll = {riseHighReg, riseLowReg};                  // [R02]
  assign fallAll = {fallHighReg, fallLowReg};                  // [R02]

  ////////////////////////////////////////////////////////////////////////
  // Edge detectors

  assign cmpLevel = {comparator2Out, comparator1Out, comparator0Out};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      assign riseSrc[gi] = riseAll[SRC_BIT_FIRST+gi];          // [R06]
      assign fallSrc[gi] = fallAll[SRC_BIT_FIRST+gi];          // [R06]
      ceis_edge_detect u_det (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .cmpIn    (cmpLevel[gi]),
        .riseEn   (riseSrc[gi]),
        .fallEn   (fallSrc[gi]),
        .irqPulse (irqVec[gi])
      );
    end
  endgenerate

  assign comparator0Irq = irqVec[0];                           // [R06]
  assign comparator1Irq = irqVec[1];                           // [R06]
  assign comparator2Irq = irqVec[2];                           // [R06]

  ////////////////////////////////////////////////////////////////////////
  // Sticky status, read to clear

  // A new event in the clearing cycle survives: set wins
  assign statusNext = ((busRead & selStat) ? STAT_RST : statusReg) | irqVec;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      statusReg <= STAT_RST;
    end else begin
      statusReg <= statusNext;
    end
  end

  assign irqOut = |(statusReg & maskReg);

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_req;
    wb_cyc_i && wb_stb_i && !ackReg;
  endsequence

  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_ack_timing;
    @(posedge mclk) disable iff (sys_rst)
      s_req |=> s_ack_once;
  endproperty
  chk_bus_ack_timing: assert property (p_ack_timing) // [R03]
    else $error("ack not given one cycle after request");

  property p_byte_write;
    @(posedge mclk) disable iff (sys_rst)
      (laneWrite && selRiseLow) |=> riseLowReg == $past(wb_dat_i[REG_W-1:0]);
  endproperty
  chk_byte_write_store: assert property (p_byte_write) // [R03]
    else $error("rise enable low byte not stored");

  property p_readback;
    @(posedge mclk) disable iff (sys_rst)
      (busRead && selFallLow) |=> wb_dat_o == {{(DAT_W-REG_W){1'b0}}, $past(fallLowReg)};
  endproperty
  chk_enable_readback: assert property (p_readback) // [R03]
    else $error("fall enable low readback wrong");

  property p_irq_sticky;
    @(posedge mclk) disable iff (sys_rst)
      irqVec[2] |=> statusReg[2];
  endproperty
  chk_status_sets: assert property (p_irq_sticky) // [R06]
    else $error("request did not set status");

  property p_high_routes;
    @(posedge mclk) disable iff (sys_rst)
      irqVec[2] |-> ($past(riseHighReg) || $past(fallHighReg));
  endproperty
  chk_high_bit_routes: assert property (p_high_routes) // [R06]
    else $error("source two request without upper enable bit");

  property p_src0_routes;
    @(posedge mclk) disable iff (sys_rst)
      irqVec[0] |-> ($past(riseLowReg[SRC_BIT_FIRST]) || $past(fallLowReg[SRC_BIT_FIRST]));
  endproperty
  chk_src0_bit_routes: assert property (p_src0_routes) // [R06]
    else $error("source zero request without its enable bit");

  property p_src1_routes;
    @(posedge mclk) disable iff (sys_rst)
      irqVec[1] |-> ($past(riseLowReg[SRC_BIT_FIRST+1]) || $past(fallLowReg[SRC_BIT_FIRST+1]));
  endproperty
  chk_src1_bit_routes: assert property (p_src1_routes) // [R06]
    else $error("source one request without its enable bit");

  // Byte lane off: the request is acked but nothing may move
  sequence s_lane_refused;
    busWrite && !wb_sel_i[0];
  endsequence

  sequence s_enables_kept;
    $stable(riseLowReg) && $stable(fallLowReg) && $stable(riseHighReg) && $stable(fallHighReg);
  endsequence

  property p_lane_refused;
    @(posedge mclk) disable iff (sys_rst)
      s_lane_refused |=> s_enables_kept;
  endproperty
  chk_lane_refused_keep: assert property (p_lane_refused) // [R03]
    else $error("write with lane off changed an enable register");

  property p_fall_low_write;
    @(posedge mclk) disable iff (sys_rst)
      (laneWrite && selFallLow) |=> fallLowReg == $past(wb_dat_i[REG_W-1:0]);
  endproperty
  chk_fall_low_store: assert property (p_fall_low_write) // [R03]
    else $error("fall enable low byte not stored");

  property p_rise_high_write;
    @(posedge mclk) disable iff (sys_rst)
      (laneWrite && selRiseHigh) |=> riseHighReg == $past(wb_dat_i[HIGH_IMPL_BIT]);
  endproperty
  chk_rise_high_store: assert property (p_rise_high_write) // [R03]
    else $error("rise enable high bit not stored");

  property p_fall_high_write;
    @(posedge mclk) disable iff (sys_rst)
      (laneWrite && selFallHigh) |=> fallHighReg == $past(wb_dat_i[HIGH_IMPL_BIT]);
  endproperty
  chk_fall_high_store: assert property (p_fall_high_write) // [R03]
    else $error("fall enable high bit not stored");

  property p_mask_write;
    @(posedge mclk) disable iff (sys_rst)
      (laneWrite && selMask) |=> maskReg == $past(wb_dat_i[NUM_SRC-1:0]);
  endproperty
  chk_mask_store: assert property (p_mask_write)
    else $error("mask not stored");

  property p_rise_low_read;
    @(posedge mclk) disable iff (sys_rst)
      (busRead && selRiseLow) |=> wb_dat_o == DAT_W'($past(riseLowReg));
  endproperty
  chk_rise_low_readback: assert property (p_rise_low_read) // [R03]
    else $error("rise enable low readback wrong");

  property p_high_read;
    @(posedge mclk) disable iff (sys_rst)
      (busRead && selFallHigh) |=> wb_dat_o == DAT_W'($past(fallHighReg));
  endproperty
  chk_high_readback: assert property (p_high_read) // [R03]
    else $error("fall enable high readback wrong");

  property p_status_read;
    @(posedge mclk) disable iff (sys_rst)
      (busRead && selStat) |=> wb_dat_o == DAT_W'($past(statusReg));
  endproperty
  chk_status_readback: assert property (p_status_read) // [R08]
    else $error("status readback wrong");

  property p_unmapped_read;
    @(posedge mclk) disable iff (sys_rst)
      (busRead && !(selRiseLow || selFallLow || selRiseHigh || selFallHigh || selStat || selMask))
        |=> wb_dat_o == '0;
  endproperty
  chk_unmapped_zero: assert property (p_unmapped_read)
    else $error("unmapped read not zero");

  property p_status_hold;
    @(posedge mclk) disable iff (sys_rst)
      (irqVec == STAT_RST && !(busRead && selStat)) |=> statusReg == $past(statusReg);
  endproperty
  chk_status_sticky: assert property (p_status_hold) // [R08]
    else $error("status changed without event or read");

  property p_ack_cause;
    @(posedge mclk) disable iff (sys_rst)
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  chk_ack_has_request: assert property (p_ack_cause) // [R03]
    else $error("ack without a request");

  property p_status_clear;
    @(posedge mclk) disable iff (sys_rst)
      (busRead && selStat && irqVec == STAT_RST) |=> statusReg == STAT_RST;
  endproperty
  chk_status_read_clear: assert property (p_status_clear)
    else $error("status not cleared by read");

endmodule : ceis_edge_select

// File: verif/ceis_cmp_model.sv
// Behavioural model of the three comparator outputs
`timescale 1ns/1ns
module ceis_cmp_model (
  // Clock
  input  wire logic       mclk,
  // Requested levels
  input  wire logic [2:0] levelReq,
  // Comparator levels
  output logic            cmp0Out,
  output logic            cmp1Out,
  output logic            cmp2Out
);
  ////////////////////////////////////////////////////////////////////////////////
  // Glitch-free levels; short pulses would be missed by the detector anyway
  always @(posedge mclk) {cmp2Out, cmp1Out, cmp0Out} <= levelReq;
endmodule : ceis_cmp_model

// File: verif/ceis_edge_select_tb_top.sv
// Self-checking bench for the comparator edge interrupt selector
`timescale 1ns/1ns
module ceis_edge_select_tb_top;
  import ceis_pkg::*;
  logic             mclk, sysRst, wbCyc, wbStb, wbWe, wbAck, comparator0_out, comparator1_out, comparator2_out, irqOut;
  logic [ADR_W-1:0] wbAdr;
  logic [DAT_W-1:0] wbDatI, wbDatO, rd;
  logic [2:0]       levelReq, irq, lvl, nxt, rise, fall, mask, expIrq;
  logic [1:0]       mode;
  logic [3:0]       wbSel;
  int               mismatches, cmp_count, seed, hits [3];

  ceis_cmp_model cmpModel (.mclk(mclk), .levelReq(levelReq), .cmp0Out(comparator0_out), .cmp1Out(comparator1_out), .cmp2Out(comparator2_out));
  ceis_edge_select uut (
    .mclk(mclk), .sys_rst(sysRst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .comparator0Out(comparator0_out), .comparator1Out(comparator1_out), .comparator2Out(comparator2_out),
    .comparator0Irq(irq[0]), .comparator1Irq(irq[1]), .comparator2Irq(irq[2]), .irqOut(irqOut));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] expectIrq(input logic [2:0] o, n, r, f);
    return (~o & n & r) | (o & ~n & f);
  endfunction : expectIrq

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Single classic cycle; waits for ack with a bound
  task automatic wbXfer(input logic we, input logic [15:0] idx, input logic [7:0] wdat, input logic [3:0] sel = 4'hF);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= sel;
    wbAdr <= {idx, 2'b00};
    wbDatI <= {24'h000000, wdat};
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (n >= 20) check(32'h0, 32'h1, "ack timeout");
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge mclk);
  endtask : wbXfer

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Run needs about 1700 cycles
  initial begin
    #(50 * 8000);
    mismatches++;
    complete_run();
  end

  initial begin
    seed = 75241;
    {sysRst, wbCyc, wbStb, wbWe, wbSel, wbAdr, wbDatI, levelReq, lvl} = {1'b1, 3'h0, 4'hF, 56'h0};
    repeat (20) @(posedge mclk);
    sysRst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 6; i++) begin
      wbXfer(1'b0, IDX_RISE_LOW + 16'(i), 8'h00);
      check(rd, 32'h0, "reset value");
    end
    for (int i = 0; i < 4; i++) begin
      wbXfer(1'b1, IDX_RISE_LOW + 16'(i), i < 2 ? 8'hFF : 8'h01);
      wbXfer(1'b0, IDX_RISE_LOW + 16'(i), 8'h00);
      check(rd, i < 2 ? 32'hFF : 32'h01, "readback");
    end
    // Low byte lane off: acked, but the register keeps its value
    wbXfer(1'b1, IDX_RISE_LOW, 8'h00, 4'hE);
    wbXfer(1'b0, IDX_RISE_LOW, 8'h00);
    check(rd, 32'hFF, "write with lane off");
    wbXfer(1'b1, 16'h0001, 8'hAA);
    wbXfer(1'b0, 16'h0001, 8'h00);
    check(rd, 32'h0, "unmapped read");
    // First four trials walk every mode through every source
    for (int t = 0; t < 48; t++) begin
      for (int s = 0; s < 3; s++) begin
        mode = (t < 4) ? 2'(t + s) : 2'($random(seed));
        {rise[s], fall[s]} = mode;
      end
      mask = 3'($random(seed));
      nxt = 3'($random(seed));
      wbXfer(1'b1, IDX_RISE_LOW, {rise[1:0], 6'h00});
      wbXfer(1'b1, IDX_FALL_LOW, {fall[1:0], 6'h00});
      wbXfer(1'b1, IDX_RISE_HIGH, {7'h00, rise[2]});
      wbXfer(1'b1, IDX_FALL_HIGH, {7'h00, fall[2]});
      wbXfer(1'b1, IDX_IRQ_MASK, {5'h00, mask});
      expIrq = expectIrq(lvl, nxt, rise, fall);
      levelReq <= nxt;
      lvl = nxt;
      hits = '{0, 0, 0};
      repeat (12) begin
        @(posedge mclk);
        for (int s = 0; s < 3; s++) hits[s] += (irq[s] === 1'b1) ? 1 : 0;
      end
      for (int s = 0; s < 3; s++) check(32'(hits[s]), {31'h0, expIrq[s]}, "request pulses");
      check({31'h0, irqOut}, {31'h0, |(expIrq & mask)}, "summary irq");
      wbXfer(1'b0, IDX_IRQ_STAT, 8'h00);
      check(rd, {29'h0, expIrq}, "status");
      wbXfer(1'b0, IDX_IRQ_STAT, 8'h00);
      check(rd, 32'h0, "status cleared");
    end
    // Mid-run reset must drop every register back to zero
    sysRst <= 1'b1;
    repeat (2) @(posedge mclk);
    sysRst <= 1'b0;
    @(posedge mclk);
    check({31'h0, irqOut}, 32'h0, "irq after reset");
    for (int i = 0; i < 6; i++) begin
      wbXfer(1'b0, IDX_RISE_LOW + 16'(i), 8'h00);
      check(rd, 32'h0, "reset value again");
    end
    complete_run();
  end
endmodule : ceis_edge_select_tb_top
